// file: hdl/psr_pkg.sv
// Register map, field positions and fixed values of the sensor register bank.
package psr_pkg;
  localparam logic [7:0] A_ALIAS = 8'h00;
  localparam logic [7:0] A_P_HI = 8'h01;
  localparam logic [7:0] A_P_MID = 8'h02;
  localparam logic [7:0] A_P_LO = 8'h03;
  localparam logic [7:0] A_T_HI = 8'h04;
  localparam logic [7:0] A_T_LO = 8'h05;
  localparam logic [7:0] A_RDY = 8'h06;
  localparam logic [7:0] A_DP_HI = 8'h07;
  localparam logic [7:0] A_DP_MID = 8'h08;
  localparam logic [7:0] A_DP_LO = 8'h09;
  localparam logic [7:0] A_DT_HI = 8'h0a;
  localparam logic [7:0] A_DT_LO = 8'h0b;
  localparam logic [7:0] A_ID = 8'h0c;
  localparam logic [7:0] A_BSTAT = 8'h0d;
  localparam logic [7:0] A_BPORT = 8'h0e;
  localparam logic [7:0] A_BSETUP = 8'h0f;
  localparam logic [7:0] A_ELAPSED = 8'h10;
  localparam logic [7:0] A_MODE = 8'h11;
  localparam logic [7:0] A_SRC = 8'h12;
  localparam logic [7:0] A_CFG = 8'h13;
  localparam logic [7:0] A_BARO_HI = 8'h14;
  localparam logic [7:0] A_BARO_LO = 8'h15;
  localparam logic [7:0] A_TGT_HI = 8'h16;
  localparam logic [7:0] A_WND_HI = 8'h19;
  localparam logic [7:0] A_WND_LO = 8'h1a;
  localparam logic [7:0] A_PMIN = 8'h1c;
  localparam logic [7:0] A_TMIN = 8'h1f;
  localparam logic [7:0] A_PMAX = 8'h21;
  localparam logic [7:0] A_TMAX = 8'h24;
  localparam logic [7:0] A_CTRL1 = 8'h26;
  localparam logic [7:0] A_LAST = 8'h2d;
  localparam logic [7:0] BARO_HI_RST = 8'hc5;
  localparam logic [7:0] BARO_LO_RST = 8'he7;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] DEV_ID = 8'h5a;
  localparam logic [6:0] I2C_ADDR = 7'h60;
  // Status, configuration and control bits, buffer modes and sizes, byte counts and bus states.
  localparam int RDY_T = 0;
  localparam int RDY_P = 1;
  localparam int RDY_PT = 2;
  localparam int OW_T = 4;
  localparam int OW_P = 5;
  localparam int OW_PT = 6;
  localparam int SRC_DRDY = 7;
  localparam int SRC_FIFO = 6;
  localparam int PRESSURE_CHANGE_EVENT = 1;
  localparam int TEMPERATURE_CHANGE_EVENT = 0;
  localparam int CFG_TEN = 0;
  localparam int CFG_PEN = 1;
  localparam int CFG_DREM = 2;
  localparam int C1_SBY = 0;
  localparam int C1_OST = 1;
  localparam int C1_ALT = 7;
  localparam int BS_OVF = 7;
  localparam int BS_WMK = 6;
  localparam logic [1:0] FM_OFF = 2'h0;
  localparam logic [1:0] FM_CIRC = 2'h1;
  localparam int FIFO_DEPTH = 32;
  localparam logic [2:0] LAST_BYTE = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] ELAPSED_MAX = 8'hff;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } psr_i2c_t;
endpackage

// file: hdl/psr_regs.sv
// Sensor register bank with its I2C slave, sample buffer and event flags.
// Behaviour
// - Pressure change beyond window sets change flag.
// - Temperature change beyond window sets change flag.
// - New sample or overwrite sets data-ready flag.
// - Data-ready source needs overwrite or ready status.
// - Buffer overflow or watermark sets buffer event.
// - Delta registers hold newest minus previous sample.
// - Track minimum and maximum pressure and temperature.
// - Address zero aliases ready or buffer status.
// - Pressure shown as three bytes, high first.
// - Temperature shown as two bytes, high first.
// - Pressure change shown as three bytes.
// - Temperature change shown as two bytes.
// - Pointer wraps from temperature delta low to status.
// - Buffer port keeps pointer, draining successive bytes.
// - Pressure high address reads buffer when enabled.
// - Fixed read-only identification register.
// - Buffer setup survives standby-to-active transition.
// - Report time elapsed since buffer overflow.
// - Pending sources register survives activation, except its data-ready bit.
// - Configuration selects which events set flags.
// - Barometric reference sixteen bits, writable, reset value.
// - Barometric reference counts two pascals per bit.
// - Activation clears live, delta, status and buffer registers but keeps extremes; standby keeps all.
// - Setup registers writable only in standby, except control and configuration.
// - Altimeter data signed, barometer data unsigned.
`timescale 1ns/1ps
`default_nettype none
module psr_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sample_valid,
  input wire logic [19:0] sample_pressure,
  input wire logic [11:0] sample_temperature,
  input wire logic second_tick,
  output logic active_mode,
  output logic altimeter_mode,
  output logic one_shot_req,
  output logic [16:0] baro_reference_pa
);
  import psr_pkg::*;

  psr_i2c_t st_r;
  logic scl_q, sda_q, rw_r, rd_stb, wr_stb;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, tx_r, ptr_r, rd_data, ptr_next;
  logic [7:0] rdy_r, src_r, cfg_r, bsetup_r, elapsed_r, ctrl1_r;
  logic [7:0] baro_hi_r, baro_lo_r, tgt_hi_r, wnd_hi_r, wnd_lo_r;
  logic [19:0] p_r, dp_r, pmin_r, pmax_r;
  logic [11:0] t_r, dt_r, tmin_r, tmax_r;
  logic prev_ok_r, mm_ok_r, ovf_r, wmk_r;
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [4:0] wr_ptr_r, rd_ptr_r;
  logic [5:0] cnt_r;
  logic [2:0] byte_idx_r;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire i2c_start = scl_in & scl_q & sda_q & ~sda_in;
  wire i2c_stop = scl_in & scl_q & ~sda_q & sda_in;
  wire standby = ~ctrl1_r[C1_SBY];
  wire fifo_on = bsetup_r[7:6] != FM_OFF;
  wire [5:0] wmk_lvl = bsetup_r[5:0];
  wire byte_done = bit_cnt_r == BYTE_BITS;
  wire go_active = wr_stb & (ptr_r == A_CTRL1) & shift_r[C1_SBY] & standby;
  wire [15:0] window = {wnd_hi_r, wnd_lo_r};

  // Deltas are computed in the sample's own number system; the wrap is the same either way.
  wire [19:0] dp_new = sample_pressure - p_r;
  wire [11:0] dt_new = sample_temperature - t_r;
  wire [19:0] dp_mag = dp_new[19] ? 20'(-dp_new) : dp_new;
  wire [11:0] dt_mag = dt_new[11] ? 12'(-dt_new) : dt_new;
  wire p_chg = prev_ok_r & (dp_mag > {4'h0, window});
  // Temperature is held against the pressure window, exactly as the device defines it.
  wire t_chg = prev_ok_r & ({4'h0, dt_mag} > window);

  // Altimeter data is two's complement, barometer data is unsigned.
  wire p_sgn = ctrl1_r[C1_ALT];
  wire p_lt_min = p_sgn ? ($signed(sample_pressure) < $signed(pmin_r))
                        : (sample_pressure < pmin_r);
  wire p_gt_max = p_sgn ? ($signed(sample_pressure) > $signed(pmax_r))
                        : (sample_pressure > pmax_r);
  wire t_lt_min = $signed(sample_temperature) < $signed(tmin_r);
  wire t_gt_max = $signed(sample_temperature) > $signed(tmax_r);

  wire on_buf_port = (ptr_r == A_BPORT) | (fifo_on & (ptr_r == A_P_HI));
  wire pop_byte = rd_stb & on_buf_port & (cnt_r != 6'h00);
  wire pop = pop_byte & (byte_idx_r == LAST_BYTE);
  wire full = cnt_r == 6'(FIFO_DEPTH);
  wire push = sample_valid & ~standby & fifo_on & (~full | bsetup_r[7:6] == FM_CIRC);
  wire drop_old = push & full;
  wire ovf_evt = sample_valid & ~standby & fifo_on & full;
  wire wmk_hit = (wmk_lvl != 6'h00) & (cnt_r >= wmk_lvl);
  wire [31:0] head = fifo_mem[rd_ptr_r];

  wire wr_ok = wr_stb & (standby | ptr_r == A_CTRL1 | ptr_r == A_CFG);
  wire rd_p = rd_stb & (ptr_r == A_P_HI) & ~fifo_on;
  wire rd_t = rd_stb & (ptr_r == A_T_HI);
  wire rd_bstat = rd_stb & (ptr_r == A_BSTAT | (fifo_on & ptr_r == A_ALIAS));

  // Read multiplexer.
  always_comb begin
    rd_data = ZERO8;
    if (ptr_r == A_ALIAS) begin
      rd_data = fifo_on ? {ovf_r, wmk_r, cnt_r} : rdy_r;
    end else if (ptr_r == A_P_HI) begin
      rd_data = p_r[19:12];
    end else if (ptr_r == A_P_MID) begin
      rd_data = p_r[11:4];
    end else if (ptr_r == A_P_LO) begin
      rd_data = {p_r[3:0], 4'h0};
    end else if (ptr_r == A_T_HI) begin
      rd_data = t_r[11:4];
    end else if (ptr_r == A_T_LO) begin
      rd_data = {t_r[3:0], 4'h0};
    end else if (ptr_r == A_RDY) begin
      rd_data = rdy_r;
    end else if (ptr_r == A_DP_HI) begin
      rd_data = dp_r[19:12];
    end else if (ptr_r == A_DP_MID) begin
      rd_data = dp_r[11:4];
    end else if (ptr_r == A_DP_LO) begin
      rd_data = {dp_r[3:0], 4'h0};
    end else if (ptr_r == A_DT_HI) begin
      rd_data = dt_r[11:4];
    end else if (ptr_r == A_DT_LO) begin
      rd_data = {dt_r[3:0], 4'h0};
    end else if (ptr_r == A_ID) begin
      rd_data = DEV_ID;
    end else if (ptr_r == A_BSTAT) begin
      rd_data = {ovf_r, wmk_r, cnt_r};
    end else if (ptr_r == A_BSETUP) begin
      rd_data = bsetup_r;
    end else if (ptr_r == A_ELAPSED) begin
      rd_data = elapsed_r;
    end else if (ptr_r == A_MODE) begin
      rd_data = {7'h00, ctrl1_r[C1_SBY]};
    end else if (ptr_r == A_SRC) begin
      rd_data = src_r;
    end else if (ptr_r == A_CFG) begin
      rd_data = cfg_r;
    end else if (ptr_r == A_BARO_HI) begin
      rd_data = baro_hi_r;
    end else if (ptr_r == A_BARO_LO) begin
      rd_data = baro_lo_r;
    end else if (ptr_r == A_TGT_HI) begin
      rd_data = tgt_hi_r;
    end else if (ptr_r == A_WND_HI) begin
      rd_data = wnd_hi_r;
    end else if (ptr_r == A_WND_LO) begin
      rd_data = wnd_lo_r;
    end else if (ptr_r == A_PMIN) begin
      rd_data = pmin_r[19:12];
    end else if (ptr_r == A_TMIN) begin
      rd_data = tmin_r[11:4];
    end else if (ptr_r == A_PMAX) begin
      rd_data = pmax_r[19:12];
    end else if (ptr_r == A_TMAX) begin
      rd_data = tmax_r[11:4];
    end else if (ptr_r == A_CTRL1) begin
      rd_data = ctrl1_r;
    end
    if (on_buf_port) begin
      // Bytes of one entry leave in pressure-high to temperature-low order.
      case (byte_idx_r)
        3'h0: rd_data = head[31:24];
        3'h1: rd_data = head[23:16];
        3'h2: rd_data = {head[15:12], 4'h0};
        3'h3: rd_data = head[11:4];
        default: rd_data = {head[3:0], 4'h0};
      endcase
    end
  end

  // Next pointer after each byte read or written.
  always_comb begin
    ptr_next = 8'(ptr_r + 8'h01);
    if (ptr_r == A_T_LO) begin
      ptr_next = A_ALIAS;
    end else if (ptr_r == A_DT_LO) begin
      ptr_next = A_RDY;
    end else if (ptr_r == A_BPORT) begin
      ptr_next = A_BPORT;
    end else if (ptr_r == A_P_HI && fifo_on) begin
      ptr_next = A_P_HI;
    end else if (ptr_r == A_LAST) begin
      ptr_next = A_ID;
    end
  end

  // I2C slave: pins are sampled on the core clock, so SCL must be slow against it.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign rd_stb = scl_fall & ((st_r == S_ADDR_ACK & rw_r) | (st_r == S_RD_ACK & ~sda_q));
  assign wr_stb = scl_fall & (st_r == S_WR) & byte_done;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= ZERO8;
      tx_r <= ZERO8;
      rw_r <= 1'b0;
      ptr_r <= ZERO8;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (i2c_start) begin
      st_r <= S_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (i2c_stop) begin
      st_r <= S_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      if (scl_rise && (st_r == S_ADDR || st_r == S_REG || st_r == S_WR)) begin
        shift_r <= {shift_r[6:0], sda_q};
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      end
      if (scl_rise && st_r == S_RD) begin
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      end
      if (scl_rise && st_r == S_RD_ACK && sda_q) begin
        st_r <= S_IDLE;
      end
      if (scl_fall) begin
        case (st_r)
          S_ADDR: begin
            if (byte_done) begin
              bit_cnt_r <= 4'h0;
              if (shift_r[7:1] == I2C_ADDR) begin
                rw_r <= shift_r[0];
                sda_oe_n <= 1'b0;
                st_r <= S_ADDR_ACK;
              end else begin
                st_r <= S_IDLE;
              end
            end
          end
          S_REG, S_WR: begin
            if (byte_done) begin
              bit_cnt_r <= 4'h0;
              sda_oe_n <= 1'b0;
              st_r <= (st_r == S_REG) ? S_REG_ACK : S_WR_ACK;
              if (st_r == S_REG) begin
                ptr_r <= shift_r;
              end else begin
                ptr_r <= ptr_next;
              end
            end
          end
          S_ADDR_ACK, S_RD_ACK: begin
            if (rw_r) begin
              tx_r <= {rd_data[6:0], 1'b0};
              sda_oe_n <= rd_data[7];
              ptr_r <= ptr_next;
              st_r <= S_RD;
            end else begin
              sda_oe_n <= 1'b1;
              st_r <= S_REG;
            end
          end
          S_REG_ACK, S_WR_ACK: begin
            sda_oe_n <= 1'b1;
            st_r <= S_WR;
          end
          S_RD: begin
            if (byte_done) begin
              sda_oe_n <= 1'b1;
              bit_cnt_r <= 4'h0;
              st_r <= S_RD_ACK;
            end else begin
              sda_oe_n <= tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // Configuration registers; none of them is touched by activation.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl1_r <= ZERO8;
      cfg_r <= ZERO8;
      bsetup_r <= ZERO8;
      baro_hi_r <= BARO_HI_RST;
      baro_lo_r <= BARO_LO_RST;
      tgt_hi_r <= ZERO8;
      wnd_hi_r <= ZERO8;
      wnd_lo_r <= ZERO8;
    end else begin
      if (sample_valid) begin
        ctrl1_r[C1_OST] <= 1'b0;
      end
      if (wr_ok) begin
        if (ptr_r == A_CTRL1) begin
          // Only standby and one-shot bits may change while active.
          ctrl1_r <= standby ? {shift_r[7:3], 1'b0, shift_r[1:0]}
                             : {ctrl1_r[7:3], 1'b0, shift_r[1:0]};
        end else if (ptr_r == A_CFG) begin
          cfg_r <= shift_r;
        end else if (ptr_r == A_BSETUP) begin
          bsetup_r <= shift_r;
        end else if (ptr_r == A_BARO_HI) begin
          baro_hi_r <= shift_r;
        end else if (ptr_r == A_BARO_LO) begin
          baro_lo_r <= shift_r;
        end else if (ptr_r == A_TGT_HI) begin
          tgt_hi_r <= shift_r;
        end else if (ptr_r == A_WND_HI) begin
          wnd_hi_r <= shift_r;
        end else if (ptr_r == A_WND_LO) begin
          wnd_lo_r <= shift_r;
        end
      end
    end
  end

  // Live data, deltas and extremes.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p_r <= 20'h0_0000;
      t_r <= 12'h000;
      dp_r <= 20'h0_0000;
      dt_r <= 12'h000;
      prev_ok_r <= 1'b0;
      mm_ok_r <= 1'b0;
      pmin_r <= 20'h0_0000;
      pmax_r <= 20'h0_0000;
      tmin_r <= 12'h000;
      tmax_r <= 12'h000;
    end else if (go_active) begin
      p_r <= 20'h0_0000;
      t_r <= 12'h000;
      dp_r <= 20'h0_0000;
      dt_r <= 12'h000;
      prev_ok_r <= 1'b0;
    end else if (sample_valid && !standby) begin
      p_r <= sample_pressure;
      t_r <= sample_temperature;
      prev_ok_r <= 1'b1;
      if (prev_ok_r) begin
        dp_r <= dp_new;
        dt_r <= dt_new;
      end
      mm_ok_r <= 1'b1;
      if (!mm_ok_r || p_lt_min) begin
        pmin_r <= sample_pressure;
      end
      if (!mm_ok_r || p_gt_max) begin
        pmax_r <= sample_pressure;
      end
      if (!mm_ok_r || t_lt_min) begin
        tmin_r <= sample_temperature;
      end
      if (!mm_ok_r || t_gt_max) begin
        tmax_r <= sample_temperature;
      end
    end
  end

  // Status and event flags; a new event wins over a clear by read in the same cycle.
  wire nv = sample_valid & ~standby;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_r <= ZERO8;
      src_r <= ZERO8;
    end else if (go_active) begin
      rdy_r <= ZERO8;
      src_r[SRC_DRDY] <= 1'b0;
    end else begin
      rdy_r[RDY_P] <= nv | (rdy_r[RDY_P] & ~rd_p);
      rdy_r[RDY_T] <= nv | (rdy_r[RDY_T] & ~rd_t);
      rdy_r[OW_P] <= (nv & rdy_r[RDY_P]) | (rdy_r[OW_P] & ~rd_p);
      rdy_r[OW_T] <= (nv & rdy_r[RDY_T]) | (rdy_r[OW_T] & ~rd_t);
      rdy_r[RDY_PT] <= (nv & (cfg_r[CFG_DREM] | ~fifo_on))
                       | (rdy_r[RDY_PT] & ~(rd_p | rd_t));
      rdy_r[OW_PT] <= (nv & rdy_r[RDY_PT]) | (rdy_r[OW_PT] & ~(rd_p | rd_t));
      src_r[SRC_DRDY] <= rdy_r[RDY_PT] | rdy_r[OW_PT];
      src_r[SRC_FIFO] <= ovf_evt | (wmk_hit & ~wmk_r) | (src_r[SRC_FIFO] & ~rd_bstat);
      src_r[PRESSURE_CHANGE_EVENT] <= (nv & p_chg & cfg_r[CFG_PEN])
                         | (src_r[PRESSURE_CHANGE_EVENT] & ~(rd_stb & ptr_r == A_DP_HI));
      src_r[TEMPERATURE_CHANGE_EVENT] <= (nv & t_chg & cfg_r[CFG_TEN])
                         | (src_r[TEMPERATURE_CHANGE_EVENT] & ~(rd_stb & ptr_r == A_DT_HI));
    end
  end

  // Sample buffer of 32 pressure and temperature pairs.
  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= {sample_pressure, sample_temperature};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
      cnt_r <= 6'h00;
      byte_idx_r <= 3'h0;
      ovf_r <= 1'b0;
      wmk_r <= 1'b0;
      elapsed_r <= ZERO8;
    end else if (go_active) begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
      cnt_r <= 6'h00;
      byte_idx_r <= 3'h0;
      ovf_r <= 1'b0;
      wmk_r <= 1'b0;
      elapsed_r <= ZERO8;
    end else begin
      if (push) begin
        wr_ptr_r <= 5'(wr_ptr_r + 5'h01);
      end
      // Circular mode drops the oldest entry, so a half-read entry is discarded too.
      if (pop || drop_old) begin
        rd_ptr_r <= 5'(rd_ptr_r + 5'h01);
      end
      if (drop_old) begin
        byte_idx_r <= 3'h0;
      end else if (pop_byte) begin
        byte_idx_r <= pop ? 3'h0 : 3'(byte_idx_r + 3'h1);
      end
      if (push && !full && !pop) begin
        cnt_r <= 6'(cnt_r + 6'h01);
      end else if (pop && !push) begin
        cnt_r <= 6'(cnt_r - 6'h01);
      end
      ovf_r <= ovf_evt | (ovf_r & ~rd_bstat);
      wmk_r <= wmk_hit;
      if (ovf_evt && !ovf_r) begin
        elapsed_r <= ZERO8;
      end else if (ovf_r && second_tick && elapsed_r != ELAPSED_MAX) begin
        elapsed_r <= 8'(elapsed_r + 8'h01);
      end
    end
  end

  // Controls toward the measurement path.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_mode <= 1'b0;
      altimeter_mode <= 1'b0;
      one_shot_req <= 1'b0;
      baro_reference_pa <= {BARO_HI_RST, BARO_LO_RST, 1'b0};
    end else begin
      active_mode <= ctrl1_r[C1_SBY];
      altimeter_mode <= ctrl1_r[C1_ALT];
      one_shot_req <= ctrl1_r[C1_OST];
      baro_reference_pa <= {baro_hi_r, baro_lo_r, 1'b0};
    end
  end
endmodule
`default_nettype wire

// file: verification/psr_regs_props.sv
// Port-level assertions for the sensor register bank.
`timescale 1ns/1ps
`default_nettype none
module psr_regs_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic sample_valid,
  input wire logic active_mode,
  input wire logic altimeter_mode,
  input wire logic one_shot_req,
  input wire logic [16:0] baro_reference_pa
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_reset_values: assert property (
    $fell(sys_rst) |-> baro_reference_pa == 17'h1_8bce && sda_oe_n && !active_mode)
    else $error("reset state wrong");
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_sda_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved while scl high");
  a_sda_stands_high: assert property (
    $rose(scl_in) |-> ##1 $stable(sda_oe_n)[*3])
    else $error("sda bit did not stand");
  a_baro_two_pa: assert property (baro_reference_pa[0] == 1'b0)
    else $error("baro reference not in two pascal steps");
  a_baro_frozen_active: assert property (
    active_mode && $past(active_mode) |-> $stable(baro_reference_pa))
    else $error("baro reference written while active");
  a_alt_frozen_active: assert property (
    $changed(altimeter_mode) |-> !$past(active_mode))
    else $error("altimeter mode written while active");
  a_oneshot_clears: assert property (
    active_mode && one_shot_req && sample_valid |-> ##2 !one_shot_req)
    else $error("one shot not cleared by sample");
  c_activate: cover property ($rose(active_mode));
  c_baro_written: cover property ($changed(baro_reference_pa));
  c_ack_driven: cover property ($fell(sda_oe_n));
endmodule
bind psr_regs psr_regs_props psr_regs_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
  .active_mode(active_mode), .altimeter_mode(altimeter_mode), .one_shot_req(one_shot_req),
  .baro_reference_pa(baro_reference_pa));
`default_nettype wire

// file: verification/psr_host.sv
// I2C bus master model standing in for the host microcontroller.
`timescale 1ns/1ps
`default_nettype none
module psr_host (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic nak_seen
);
  import psr_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nak_seen = 1'b0;
  end
  task automatic half;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic start;
    sda_low <= 1'b0;
    half;
    scl <= 1'b1;
    half;
    sda_low <= 1'b1;
    half;
    scl <= 1'b0;
    half;
  endtask
  // A spare cycle after each fall keeps data changes clear of the start detector.
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    half;
    scl <= 1'b1;
    half;
    r = sda;
    scl <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic xfer(input logic [7:0] d, input logic rel, input logic want, output logic [7:0] q);
    logic ack;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(rel, ack);
    if (want && ack) nak_seen = 1'b1;
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    half;
    scl <= 1'b1;
    half;
    sda_low <= 1'b0;
    half;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    start;
    xfer({I2C_ADDR, 1'b0}, 1'b1, 1'b1, x);
    xfer(a, 1'b1, 1'b1, x);
    xfer(d, 1'b1, 1'b1, x);
    stop;
  endtask
  task automatic read_burst(input logic [7:0] a, input int n, output logic [7:0] q [8]);
    logic [7:0] x;
    start;
    xfer({I2C_ADDR, 1'b0}, 1'b1, 1'b1, x);
    xfer(a, 1'b1, 1'b1, x);
    start;
    xfer({I2C_ADDR, 1'b1}, 1'b1, 1'b1, x);
    for (int i = 0; i < n; i++) xfer(8'hff, i == n - 1, 1'b0, q[i]);
    stop;
  endtask
endmodule
`default_nettype wire

// file: verification/psr_regs_tb.sv
// Self-checking bench for the sensor register bank.
`timescale 1ns/1ps
`default_nettype none
module psr_regs_tb;
  import psr_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid = 1'b0;
  logic [19:0] sample_pressure = 20'h0_0000;
  logic [11:0] sample_temperature = 12'h000;
  logic second_tick = 1'b0;
  logic scl, sda_low, nak_seen, sda_out, sda_oe_n, active_mode, altimeter_mode, one_shot_req;
  logic [16:0] baro_reference_pa;
  logic [7:0] q [8];
  int n_mismatch = 0;
  int checks = 0;
  wire logic sda;
  // The bus line has a pull-up, so it reads high whenever nobody pulls it.
  assign sda = !(sda_low || (!sda_oe_n && !sda_out));
  always #5 core_clk = ~core_clk;
  psr_host psr_host_i (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .nak_seen(nak_seen));
  psr_regs psr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
    .sample_pressure(sample_pressure), .sample_temperature(sample_temperature),
    .second_tick(second_tick), .active_mode(active_mode), .altimeter_mode(altimeter_mode),
    .one_shot_req(one_shot_req), .baro_reference_pa(baro_reference_pa));
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    psr_host_i.write_reg(a, d);
  endtask
  task automatic rdb(input logic [7:0] a, input int n, input logic [63:0] e);
    psr_host_i.read_burst(a, n, q);
    for (int i = 0; i < n; i++) chk($sformatf("reg %h byte %0d", a, i), 20'(e[63-8*i -: 8]), 20'(q[i]));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdb(a, 1, {e, 56'h0});
  endtask
  task automatic smp(input logic [19:0] p, input logic [11:0] t);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_pressure <= p;
    sample_temperature <= t;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reset;
    chk("baro port", 20'h1_8bce, {3'h0, baro_reference_pa});
    rd(A_BARO_HI, BARO_HI_RST);
    rd(A_BARO_LO, BARO_LO_RST);
    rd(A_ID, DEV_ID);
    rd(A_MODE, 8'h00);
    rd(A_BSETUP, 8'h00);
    rd(8'h30, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_config;
    wr(A_BARO_HI, 8'h12);
    wr(A_BARO_LO, 8'h34);
    chk("baro port", 20'h0_2468, {3'h0, baro_reference_pa});
    rd(A_BARO_LO, 8'h34);
    wr(A_CFG, 8'h07);
    wr(A_WND_LO, 8'h05);
    wr(A_CTRL1, 8'h03);
    chk("active", 20'h1, {19'h0, active_mode});
    chk("one shot", 20'h1, {19'h0, one_shot_req});
    rd(A_MODE, 8'h01);
    wr(A_BARO_HI, 8'h55);
    rd(A_BARO_HI, 8'h12);
    $display("t_config done");
  endtask
  task automatic t_samples;
    smp(20'h1_2345, 12'habc);
    chk("one shot", 20'h0, {19'h0, one_shot_req});
    rdb(A_ALIAS, 7, 64'h0712_3450_abc0_0000);
    smp(20'h1_2300, 12'hab0);
    rd(A_SRC, 8'h83);
    rdb(A_DP_HI, 6, 64'hfffb_b0ff_4007_0000);
    rd(A_SRC, 8'h80);
    $display("t_samples done");
  endtask
  task automatic t_minmax;
    smp(20'h5_6789, 12'h123);
    rd(A_RDY, 8'h77);
    rd(A_PMIN, 8'h12);
    rd(A_TMIN, 8'hab);
    rd(A_PMAX, 8'h56);
    rd(A_TMAX, 8'h12);
    $display("t_minmax done");
  endtask
  task automatic t_buffer;
    wr(A_CTRL1, 8'h00);
    rd(A_RDY, 8'h77);
    wr(A_BSETUP, 8'h81);
    wr(A_CTRL1, 8'h01);
    rd(A_BSETUP, 8'h81);
    rd(A_RDY, 8'h00);
    rd(A_SRC, 8'h03);
    smp(20'h0_abcd, 12'h321);
    rd(A_SRC, 8'hc3);
    rd(A_ALIAS, 8'h41);
    rdb(A_P_HI, 5, 64'h0abc_d032_1000_0000);
    $display("t_buffer done");
  endtask
  task automatic t_overflow;
    for (int i = 0; i < 33; i++) smp(20'h1_0000 + 20'(i), 12'h100 + 12'(i));
    // Ticks come before the status read, since that read ends the overflow and its count.
    repeat (3) begin
      @(posedge core_clk);
      second_tick <= 1'b1;
      @(posedge core_clk);
      second_tick <= 1'b0;
    end
    rd(A_BSTAT, 8'he0);
    rd(A_ELAPSED, 8'h03);
    rdb(A_BPORT, 5, 64'h1000_0010_0000_0000);
    $display("t_overflow done");
  endtask
  task automatic t_altitude;
    wr(A_CTRL1, 8'h00);
    wr(A_CTRL1, 8'h81);
    chk("alt mode", 20'h1, {19'h0, altimeter_mode});
    smp(20'hf_0000, 12'h000);
    rd(A_PMIN, 8'hf0);
    rd(A_PMAX, 8'h56);
    $display("t_altitude done");
  endtask
  task automatic final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset;
    t_config;
    t_samples;
    t_minmax;
    t_buffer;
    t_overflow;
    t_altitude;
    chk("bus ack", 20'h0, {19'h0, nak_seen});
    final_report;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
